/* File: hdl/exposure_gain_sync_regs.v */
// Exposure, frame period and gain register bank of the readout sequencer,
// with frame-start synchronised shadow copies and a global shutter time base.
// Assumes a decoded configuration port (address, data, strobes) from the
// serial interface, and a one-cycle frame start pulse from the sequencer.
//
// How it works
// R1 - Period field used only in global shutter
// R2 - Representation bit picks reset or frame length
// R3 - Exposure counts lines rolling, timer units global
// R4 - Second slope time only for global shutter
// R5 - Latency bit delays gain one extra frame
// R6 - Line length sync bit holds until frame
// R7 - Dark row sync bit holds until frame
// R8 - Padding row sync bit holds until frame
// R9 - Exposure sync bit holds exposure until frame
// R10 - Gain sync bit holds gain until frame
// R11 - Timer multiplier sets global time unit
// R12 - Shadow copies load at frame; readback written
`timescale 1ns/10ps
`include "exposure_gain_sync_map.vh"

module exposure_gain_sync_regs #(
    parameter AW = 9,    // Configuration address width
    parameter DW = 16    // Configuration data width
) (
    // Clock and reset
    input  wire          core_clk_i,
    input  wire          rst_i,
    // Configuration port
    input  wire [AW-1:0] cfg_addr_i,
    input  wire [DW-1:0] cfg_wdata_i,
    input  wire          cfg_wr_i,
    input  wire          cfg_rd_i,
    output wire [DW-1:0] cfg_rdata_o,
    output wire          cfg_rvalid_o,
    // Sequencer status and loose settings
    input  wire          frame_start_i,
    input  wire          line_tick_i,
    input  wire          global_shutter_i,
    input  wire          period_representation_bit_i,
    input  wire [15:0]   timer_multiplier_i,
    input  wire [7:0]    rolling_line_duration_i,
    input  wire [7:0]    dark_row_count_i,
    input  wire [11:0]   padding_row_count_i,
    // Active timing values
    output wire [7:0]    rolling_line_duration_o,
    output wire [7:0]    dark_row_count_o,
    output wire [11:0]   padding_row_count_o,
    output wire [15:0]   reset_length_o,
    output wire [15:0]   frame_length_o,
    output wire [15:0]   exposure_time_o,
    output wire [15:0]   second_slope_exposure_o,
    output wire [15:0]   third_slope_exposure_o,
    output wire          exposure_tick_o,
    output wire          timer_unit_tick_o,
    // Active gain values
    output wire [1:0]    first_amp_setting_o,
    output wire [3:0]    second_amp_setting_o,
    output wire [11:0]   digital_multiplier_o
);

    // Programmed (readback) copies of the registers
    reg [15:0] period_field_r;
    reg [15:0] exposure_time_r;
    reg [15:0] second_slope_time_r;
    reg [15:0] third_slope_time_r;
    reg [15:0] analog_gain_setup_r;
    reg [15:0] digital_gain_setup_r;
    reg [15:0] frame_update_sync_ctrl_r;

    // Read data path
    reg [DW-1:0] rdata_r;
    reg [DW-1:0] rdata_nxt;
    reg          rvalid_r;

    // Gain pipeline: pending stage and active stage
    reg [27:0] gain_pend_r;      // Gain caught at the first frame start
    reg [27:0] gain_act_r;       // Gain driving the amplifiers
    reg [27:0] gain_act_nxt;
    wire [27:0] gain_written;    // Digital and analog gain as written
    // Reset gain word; only the low 12 bits of the digital word are kept
    localparam [31:0] GAIN_RST_WORD = {`EGS_RST_DIGITAL_GAIN, `EGS_RST_ANALOG_GAIN};

    // Global shutter time base
    reg  [15:0] unit_cnt_r;
    reg  [15:0] unit_cnt_nxt;
    wire [15:0] unit_len;        // Cycles per time unit, zero read as one
    wire        unit_tick;

    // Active copies from the shadow registers
    wire [63:0] expo_group;      // Period, exposure and both slope times
    wire [63:0] expo_active;

    // Sync control bits and the gain latency bit, decoded for readability
    wire sync_line   = frame_update_sync_ctrl_r[`EGS_SYNC_LINE_LENGTH];
    wire sync_dark   = frame_update_sync_ctrl_r[`EGS_SYNC_DARK_ROWS];
    wire sync_pad    = frame_update_sync_ctrl_r[`EGS_SYNC_PADDING_ROWS];
    wire sync_expo   = frame_update_sync_ctrl_r[`EGS_SYNC_EXPOSURE];
    wire sync_gain   = frame_update_sync_ctrl_r[`EGS_SYNC_GAIN];
    wire gain_late   = analog_gain_setup_r[`EGS_GAIN_LATENCY_BIT];

    // Address match helper, shared by write and read decode
    function hit;
        input [AW-1:0] addr;
        input [8:0]    target;
        begin
            hit = (addr == target[AW-1:0]);
        end
    endfunction

    // Register writes; readback always returns what was last written
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            period_field_r           <= `EGS_RST_PERIOD;
            exposure_time_r          <= `EGS_RST_EXPOSURE;
            second_slope_time_r      <= `EGS_RST_SECOND_SLOPE;
            third_slope_time_r       <= `EGS_RST_THIRD_SLOPE;
            analog_gain_setup_r      <= `EGS_RST_ANALOG_GAIN;
            digital_gain_setup_r     <= `EGS_RST_DIGITAL_GAIN;
            frame_update_sync_ctrl_r <= `EGS_RST_SYNC_CTRL;
        end else if (cfg_wr_i) begin
            if (hit(cfg_addr_i, `EGS_ADDR_PERIOD)) begin
                period_field_r <= cfg_wdata_i;
            end
            if (hit(cfg_addr_i, `EGS_ADDR_EXPOSURE)) begin
                exposure_time_r <= cfg_wdata_i;
            end
            if (hit(cfg_addr_i, `EGS_ADDR_SECOND_SLOPE)) begin
                second_slope_time_r <= cfg_wdata_i;
            end
            if (hit(cfg_addr_i, `EGS_ADDR_THIRD_SLOPE)) begin
                third_slope_time_r <= cfg_wdata_i;
            end
            if (hit(cfg_addr_i, `EGS_ADDR_ANALOG_GAIN)) begin
                analog_gain_setup_r <= cfg_wdata_i;
            end
            if (hit(cfg_addr_i, `EGS_ADDR_DIGITAL_GAIN)) begin
                digital_gain_setup_r <= cfg_wdata_i;
            end
            if (hit(cfg_addr_i, `EGS_ADDR_SYNC_CTRL)) begin
                frame_update_sync_ctrl_r <= cfg_wdata_i;
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always @* begin
        rdata_nxt = {DW{1'b0}};
        if (hit(cfg_addr_i, `EGS_ADDR_PERIOD)) begin
            rdata_nxt = period_field_r;
        end else if (hit(cfg_addr_i, `EGS_ADDR_EXPOSURE)) begin
            rdata_nxt = exposure_time_r;                          // R12
        end else if (hit(cfg_addr_i, `EGS_ADDR_SECOND_SLOPE)) begin
            rdata_nxt = second_slope_time_r;
        end else if (hit(cfg_addr_i, `EGS_ADDR_THIRD_SLOPE)) begin
            rdata_nxt = third_slope_time_r;
        end else if (hit(cfg_addr_i, `EGS_ADDR_ANALOG_GAIN)) begin
            rdata_nxt = analog_gain_setup_r;
        end else if (hit(cfg_addr_i, `EGS_ADDR_DIGITAL_GAIN)) begin
            rdata_nxt = digital_gain_setup_r;
        end else if (hit(cfg_addr_i, `EGS_ADDR_SYNC_CTRL)) begin
            rdata_nxt = frame_update_sync_ctrl_r;
        end
    end

    // Read data register, valid one cycle after the read strobe
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_r  <= {DW{1'b0}};
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= cfg_rd_i;
            if (cfg_rd_i) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign cfg_rdata_o  = rdata_r;
    assign cfg_rvalid_o = rvalid_r;

    // Line timing shadows, each with its own sync bit
    frame_sync_shadow #(.W(8), .RST_VALUE(8'h00)) u_line_len (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .sync_en_i     (sync_line),                                // R6
        .frame_start_i (frame_start_i),
        .value_i       (rolling_line_duration_i),
        .active_o      (rolling_line_duration_o)
    );

    frame_sync_shadow #(.W(8), .RST_VALUE(8'h00)) u_dark_rows (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .sync_en_i     (sync_dark),                                // R7
        .frame_start_i (frame_start_i),
        .value_i       (dark_row_count_i),
        .active_o      (dark_row_count_o)
    );

    frame_sync_shadow #(.W(12), .RST_VALUE(12'h000)) u_pad_rows (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .sync_en_i     (sync_pad),                                 // R8
        .frame_start_i (frame_start_i),
        .value_i       (padding_row_count_i),
        .active_o      (padding_row_count_o)
    );

    // Exposure group shares one sync bit so all times switch together
    assign expo_group = {period_field_r, exposure_time_r,
                         second_slope_time_r, third_slope_time_r};

    frame_sync_shadow #(.W(64), .RST_VALUE(64'h0)) u_expo (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .sync_en_i     (sync_expo),                                // R9
        .frame_start_i (frame_start_i),
        .value_i       (expo_group),
        .active_o      (expo_active)                               // R12
    );

    // Period feeds only global shutter; bit picks its meaning
    assign reset_length_o = (global_shutter_i && !period_representation_bit_i) ?
                            expo_active[63:48] : 16'h0000;         // R1 R2
    assign frame_length_o = (global_shutter_i && period_representation_bit_i) ?
                            expo_active[63:48] : 16'h0000;         // R1 R2
    assign exposure_time_o = expo_active[47:32];
    // Slope times have no meaning in rolling shutter, so they read zero there
    assign second_slope_exposure_o = global_shutter_i ? expo_active[31:16] :
                                     16'h0000;                     // R4
    assign third_slope_exposure_o  = global_shutter_i ? expo_active[15:0] :
                                     16'h0000;

    // Time unit counter; a zero multiplier would stall, so it acts as one
    assign unit_len  = (timer_multiplier_i == 16'h0000) ? 16'h0001 :
                       timer_multiplier_i;                         // R11
    assign unit_tick = global_shutter_i && (unit_cnt_r == unit_len - 16'h0001);

    always @* begin
        unit_cnt_nxt = unit_cnt_r + 16'h0001;
        // Realign the unit grid to each frame so exposure starts clean
        if (!global_shutter_i || frame_start_i || unit_tick) begin
            unit_cnt_nxt = 16'h0000;
        end
    end

    // Time unit counter register
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            unit_cnt_r <= 16'h0000;
        end else begin
            unit_cnt_r <= unit_cnt_nxt;
        end
    end

    assign timer_unit_tick_o = unit_tick;
    // Exposure granularity: lines when rolling, timer units when global
    assign exposure_tick_o   = global_shutter_i ? unit_tick : line_tick_i; // R3

    // Gain pipeline
    assign gain_written = {digital_gain_setup_r[`EGS_DIGITAL_MULT_MSB:0],
                           analog_gain_setup_r};

    always @* begin
        gain_act_nxt = gain_act_r;
        if (!sync_gain) begin
            gain_act_nxt = gain_written;                           // R10
        end else if (frame_start_i) begin
            // Extra frame of delay lines gain up with exposure latency
            gain_act_nxt = gain_late ? gain_pend_r : gain_written; // R5
        end
    end

    // Gain pending and active registers
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            gain_pend_r <= GAIN_RST_WORD[27:0];
            gain_act_r  <= GAIN_RST_WORD[27:0];
        end else begin
            if (frame_start_i || !sync_gain) begin
                gain_pend_r <= gain_written;                       // R5
            end
            gain_act_r <= gain_act_nxt;
        end
    end

    assign first_amp_setting_o  = gain_act_r[`EGS_FIRST_AMP_MSB:`EGS_FIRST_AMP_LSB];
    assign second_amp_setting_o = gain_act_r[`EGS_SECOND_AMP_MSB:`EGS_SECOND_AMP_LSB];
    assign digital_multiplier_o = gain_act_r[27:16];

endmodule // exposure_gain_sync_regs

/* File: hdl/exposure_gain_sync_map.vh */
// Register offsets, field positions and reset values of the exposure and
// gain register bank. Definitions only; included by the bank's top module and its bench.
`ifndef EXPOSURE_GAIN_SYNC_MAP_VH
`define EXPOSURE_GAIN_SYNC_MAP_VH

// Register addresses on the internal configuration port (9-bit)
`define EGS_ADDR_PERIOD        9'h0c8
`define EGS_ADDR_EXPOSURE      9'h0c9
`define EGS_ADDR_SECOND_SLOPE  9'h0ca
`define EGS_ADDR_THIRD_SLOPE   9'h0cb
`define EGS_ADDR_ANALOG_GAIN   9'h0cc
`define EGS_ADDR_DIGITAL_GAIN  9'h0cd
`define EGS_ADDR_SYNC_CTRL     9'h0ce

// Reset values
`define EGS_RST_PERIOD         16'h0000
`define EGS_RST_EXPOSURE       16'h0000
`define EGS_RST_SECOND_SLOPE   16'h0000
`define EGS_RST_THIRD_SLOPE    16'h0000
`define EGS_RST_ANALOG_GAIN    16'h01e2
`define EGS_RST_DIGITAL_GAIN   16'h0080
`define EGS_RST_SYNC_CTRL      16'h033f

// Analog gain fields
`define EGS_FIRST_AMP_LSB      0
`define EGS_FIRST_AMP_MSB      1
`define EGS_SECOND_AMP_LSB     5
`define EGS_SECOND_AMP_MSB     8
`define EGS_GAIN_LATENCY_BIT   13

// Digital gain field
`define EGS_DIGITAL_MULT_MSB   11

// Frame update sync control fields
`define EGS_SYNC_LINE_LENGTH   0
`define EGS_SYNC_DARK_ROWS     1
`define EGS_SYNC_PADDING_ROWS  2
`define EGS_SYNC_EXPOSURE      3
`define EGS_SYNC_GAIN          4

`endif

/* File: hdl/frame_sync_shadow.v */
// Shadow register that copies a programmed value into its active copy,
// either every cycle or only at frame start, as chosen by sync_en_i.
// Assumes frame_start_i is a one-cycle pulse in the core clock domain.
`timescale 1ns/10ps

module frame_sync_shadow #(
    parameter W         = 16,          // Width of the shadowed value
    parameter RST_VALUE = {W{1'b0}}    // Active value after reset
) (
    // Clock and reset
    input  wire         core_clk_i,
    input  wire         rst_i,
    // Control
    input  wire         sync_en_i,
    input  wire         frame_start_i,
    // Data
    input  wire [W-1:0] value_i,
    output wire [W-1:0] active_o
);

    reg [W-1:0] active_r;     // Value the sequencer works with
    reg [W-1:0] active_nxt;   // Next active value

    // Follow the programmed value at once, or hold it until frame start
    always @* begin
        active_nxt = active_r;
        if (!sync_en_i || frame_start_i) begin
            active_nxt = value_i;
        end
    end

    // Active copy register
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            active_r <= RST_VALUE;
        end else begin
            active_r <= active_nxt;
        end
    end

    assign active_o = active_r;

endmodule // frame_sync_shadow

/* File: tb/exposure_gain_sync_regs_properties.sv */
// Timing checks for the exposure and gain register bank.
// Assumes only the bank's top-level ports; bound in after the module.
`timescale 1ns/10ps

module exposure_gain_sync_regs_properties #(
    parameter AW = 9,   // Address width, handed on by the bind
    parameter DW = 16   // Data width, handed on by the bind
) (
    // Clock and reset
    input wire        core_clk_i,
    input wire        rst_i,
    // Read handshake
    input wire        cfg_rd_i,
    input wire        cfg_rvalid_o,
    // Sequencer inputs
    input wire        frame_start_i,
    input wire        line_tick_i,
    input wire        global_shutter_i,
    input wire        period_representation_bit_i,
    input wire [7:0]  rolling_line_duration_i,
    input wire [7:0]  dark_row_count_i,
    input wire [11:0] padding_row_count_i,
    // Active values
    input wire [7:0]  rolling_line_duration_o,
    input wire [7:0]  dark_row_count_o,
    input wire [11:0] padding_row_count_o,
    input wire [15:0] reset_length_o,
    input wire [15:0] frame_length_o,
    input wire [15:0] second_slope_exposure_o,
    input wire [15:0] third_slope_exposure_o,
    input wire        exposure_tick_o,
    input wire        timer_unit_tick_o
);
    // One clock domain, so clocking and disable are given once
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Mode inputs held two cycles, so a registered mode path is also fine
    sequence s_roll; !global_shutter_i [*2]; endsequence
    property p_rd_answer; cfg_rd_i |=> cfg_rvalid_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_quiet; !cfg_rd_i |=> !cfg_rvalid_o; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
    property p_period_roll; s_roll |-> reset_length_o == 16'h0000 && frame_length_o == 16'h0000;
    endproperty
    a_period_roll: assert property (p_period_roll) else $error("period used when rolling");
    property p_rep_reset;
        (global_shutter_i && !period_representation_bit_i) [*2] |-> frame_length_o == 16'h0000;
    endproperty
    a_rep_reset: assert property (p_rep_reset) else $error("frame length in reset mode");
    property p_rep_frame;
        (global_shutter_i && period_representation_bit_i) [*2] |-> reset_length_o == 16'h0000;
    endproperty
    a_rep_frame: assert property (p_rep_frame) else $error("reset length in frame mode");
    property p_slope_roll;
        s_roll |-> second_slope_exposure_o == 16'h0000 && third_slope_exposure_o == 16'h0000;
    endproperty
    a_slope_roll: assert property (p_slope_roll) else $error("slope time when rolling");
    property p_line_unit; !global_shutter_i |-> exposure_tick_o == line_tick_i; endproperty
    a_line_unit: assert property (p_line_unit) else $error("rolling unit not lines");
    property p_timer_off; s_roll |-> !timer_unit_tick_o; endproperty
    a_timer_off: assert property (p_timer_off) else $error("timer tick when rolling");
    // An active copy may only ever take the programmed value
    property p_line_len;
        !$past(rst_i) && $changed(rolling_line_duration_o)
            |-> rolling_line_duration_o == $past(rolling_line_duration_i);
    endproperty
    a_line_len: assert property (p_line_len) else $error("line length bad load");
    property p_dark;
        !$past(rst_i) && $changed(dark_row_count_o)
            |-> dark_row_count_o == $past(dark_row_count_i);
    endproperty
    a_dark: assert property (p_dark) else $error("dark rows bad load");
    property p_pad;
        !$past(rst_i) && $changed(padding_row_count_o)
            |-> padding_row_count_o == $past(padding_row_count_i);
    endproperty
    a_pad: assert property (p_pad) else $error("padding rows bad load");

    // Main scenarios reached
    c_frame: cover property (frame_start_i && global_shutter_i);
    c_tick: cover property (timer_unit_tick_o);
    c_read: cover property (cfg_rd_i ##1 cfg_rvalid_o);
endmodule // exposure_gain_sync_regs_properties

bind exposure_gain_sync_regs exposure_gain_sync_regs_properties #(.AW(AW), .DW(DW)) u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_rd_i(cfg_rd_i), .cfg_rvalid_o(cfg_rvalid_o),
    .frame_start_i(frame_start_i), .line_tick_i(line_tick_i),
    .global_shutter_i(global_shutter_i),
    .period_representation_bit_i(period_representation_bit_i),
    .rolling_line_duration_i(rolling_line_duration_i), .dark_row_count_i(dark_row_count_i),
    .padding_row_count_i(padding_row_count_i), .rolling_line_duration_o(rolling_line_duration_o),
    .dark_row_count_o(dark_row_count_o), .padding_row_count_o(padding_row_count_o),
    .reset_length_o(reset_length_o), .frame_length_o(frame_length_o),
    .second_slope_exposure_o(second_slope_exposure_o),
    .third_slope_exposure_o(third_slope_exposure_o),
    .exposure_tick_o(exposure_tick_o), .timer_unit_tick_o(timer_unit_tick_o));

/* File: tb/exposure_gain_sync_regs_tb.sv */
// Self-checking bench for the exposure and gain register bank.
// Assumes the bank's map header on the include path; drives all ports itself.
`timescale 1ns/10ps
`include "exposure_gain_sync_map.vh"

module exposure_gain_sync_regs_tb;
    // Stimulus, always changed 1 ns after a rising edge
    logic core_clk_i = 0, rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, frame_start_i = 0;
    logic line_tick_i = 0, global_shutter_i = 1, period_representation_bit_i = 0;
    logic [8:0]  cfg_addr_i = 9'h000;
    logic [15:0] cfg_wdata_i = 16'h0000, timer_multiplier_i = 16'h0001;
    logic [7:0]  rolling_line_duration_i = 8'h00, dark_row_count_i = 8'h00;
    logic [11:0] padding_row_count_i = 12'h000;
    // Observed outputs
    wire [15:0] cfg_rdata_o, reset_length_o, frame_length_o, exposure_time_o;
    wire [15:0] second_slope_exposure_o, third_slope_exposure_o;
    wire [7:0]  rolling_line_duration_o, dark_row_count_o;
    wire [11:0] padding_row_count_o, digital_multiplier_o;
    wire [3:0]  second_amp_setting_o;
    wire [1:0]  first_amp_setting_o;
    wire        cfg_rvalid_o, exposure_tick_o, timer_unit_tick_o;
    int miscompares = 0, samples_checked = 0, n;
    // Reset values, lowest address in the low word
    localparam [111:0] RV = {`EGS_RST_SYNC_CTRL, `EGS_RST_DIGITAL_GAIN, `EGS_RST_ANALOG_GAIN,
        `EGS_RST_THIRD_SLOPE, `EGS_RST_SECOND_SLOPE, `EGS_RST_EXPOSURE, `EGS_RST_PERIOD};

    always #5 core_clk_i = ~core_clk_i;

    exposure_gain_sync_regs dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_wr_i(cfg_wr_i),
        .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .frame_start_i(frame_start_i), .line_tick_i(line_tick_i),
        .global_shutter_i(global_shutter_i),
        .period_representation_bit_i(period_representation_bit_i),
        .timer_multiplier_i(timer_multiplier_i),
        .rolling_line_duration_i(rolling_line_duration_i), .dark_row_count_i(dark_row_count_i),
        .padding_row_count_i(padding_row_count_i),
        .rolling_line_duration_o(rolling_line_duration_o), .dark_row_count_o(dark_row_count_o),
        .padding_row_count_o(padding_row_count_o), .reset_length_o(reset_length_o),
        .frame_length_o(frame_length_o), .exposure_time_o(exposure_time_o),
        .second_slope_exposure_o(second_slope_exposure_o),
        .third_slope_exposure_o(third_slope_exposure_o), .exposure_tick_o(exposure_tick_o),
        .timer_unit_tick_o(timer_unit_tick_o), .first_amp_setting_o(first_amp_setting_o),
        .second_amp_setting_o(second_amp_setting_o),
        .digital_multiplier_o(digital_multiplier_o));

    // Advance to 1 ns past the n-th rising edge
    task step(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask
    task stop_test;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Single compare for every value; narrow fields are zero-extended
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Strobes drop for a cycle between transfers, so no pin toggles twice per step
    task wr(input logic [8:0] a, input logic [15:0] d);
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_wr_i = 1;
        step(1);
        cfg_wr_i = 0;
        step(1);
    endtask
    // Answer stands from the taking edge itself and is checked 1 ns after it
    task rd(input logic [8:0] a, input logic [15:0] exp);
        cfg_addr_i = a;
        cfg_rd_i = 1;
        step(1);
        cfg_rd_i = 0;
        chk({15'h0000, cfg_rvalid_o}, 16'h0001);
        chk(cfg_rdata_o, exp);
        step(1);
    endtask
    task fs;
        frame_start_i = 1;
        step(1);
        frame_start_i = 0;
    endtask
    task do_reset;
        rst_i = 1;
        step(3);
        rst_i = 0;
    endtask

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        stop_test;
    end

    initial begin
        do_reset;
        for (int i = 0; i < 7; i++) rd(9'(9'h0c8 + i), RV[16*i +: 16]);
        rd(9'h0c7, 16'h0000);
        chk({14'h0, first_amp_setting_o}, 16'h0002);
        chk({12'h0, second_amp_setting_o}, 16'h000f);
        chk({4'h0, digital_multiplier_o}, 16'h0080);
        $display("test reset values done");
        for (int i = 0; i < 7; i++) wr(9'(9'h0c8 + i), 16'(16'h1e00 + i));
        wr(9'h0cf, 16'hffff);
        for (int i = 0; i < 7; i++) rd(9'(9'h0c8 + i), 16'(16'h1e00 + i));
        rd(9'h0cf, 16'h0000);
        $display("test readback done");
        do_reset;
        // Exposure group waits for frame start while its sync bit is set
        wr(`EGS_ADDR_EXPOSURE, 16'h1234);
        wr(`EGS_ADDR_PERIOD, 16'h0abc);
        wr(`EGS_ADDR_SECOND_SLOPE, 16'h0055);
        wr(`EGS_ADDR_THIRD_SLOPE, 16'h0066);
        chk(exposure_time_o, 16'h0000);
        chk(reset_length_o, 16'h0000);
        fs;
        chk(exposure_time_o, 16'h1234);
        chk(reset_length_o, 16'h0abc);
        chk(second_slope_exposure_o, 16'h0055);
        chk(third_slope_exposure_o, 16'h0066);
        period_representation_bit_i = 1;
        step(2);
        chk(frame_length_o, 16'h0abc);
        chk(reset_length_o, 16'h0000);
        global_shutter_i = 0;
        step(2);
        chk(frame_length_o, 16'h0000);
        chk(second_slope_exposure_o, 16'h0000);
        chk(third_slope_exposure_o, 16'h0000);
        global_shutter_i = 1;
        wr(`EGS_ADDR_SYNC_CTRL, 16'h0337);
        wr(`EGS_ADDR_EXPOSURE, 16'h4321);
        step(1);
        chk(exposure_time_o, 16'h4321);
        $display("test exposure sync done");
        // Gain: synced, then one frame late, then free running
        wr(`EGS_ADDR_ANALOG_GAIN, 16'h0061);
        wr(`EGS_ADDR_DIGITAL_GAIN, 16'h0123);
        chk({14'h0, first_amp_setting_o}, 16'h0002);
        fs;
        chk({14'h0, first_amp_setting_o}, 16'h0001);
        chk({12'h0, second_amp_setting_o}, 16'h0003);
        chk({4'h0, digital_multiplier_o}, 16'h0123);
        wr(`EGS_ADDR_ANALOG_GAIN, 16'h20a2);
        fs;
        chk({14'h0, first_amp_setting_o}, 16'h0001);
        fs;
        chk({14'h0, first_amp_setting_o}, 16'h0002);
        chk({12'h0, second_amp_setting_o}, 16'h0005);
        wr(`EGS_ADDR_SYNC_CTRL, 16'h032f);
        wr(`EGS_ADDR_ANALOG_GAIN, 16'h0043);
        step(1);
        chk({14'h0, first_amp_setting_o}, 16'h0003);
        chk({12'h0, second_amp_setting_o}, 16'h0002);
        $display("test gain sync done");
        // Line timing copies: held, then immediate
        rolling_line_duration_i = 8'h5a;
        dark_row_count_i = 8'h07;
        padding_row_count_i = 12'h9ab;
        step(2);
        chk({rolling_line_duration_o, dark_row_count_o}, 16'h0000);
        chk({4'h0, padding_row_count_o}, 16'h0000);
        fs;
        chk({rolling_line_duration_o, dark_row_count_o}, 16'h5a07);
        chk({4'h0, padding_row_count_o}, 16'h09ab);
        wr(`EGS_ADDR_SYNC_CTRL, 16'h0338);
        rolling_line_duration_i = 8'ha5;
        dark_row_count_i = 8'h70;
        padding_row_count_i = 12'h0ba;
        step(2);
        chk({rolling_line_duration_o, dark_row_count_o}, 16'ha570);
        chk({4'h0, padding_row_count_o}, 16'h00ba);
        $display("test line sync done");
        // Time base: four clocks per unit gives ten ticks in forty cycles
        timer_multiplier_i = 16'h0004;
        fs;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            n += timer_unit_tick_o;
            chk({15'h0000, exposure_tick_o}, 16'(k % 4 == 3));
            step(1);
        end
        chk(16'(n), 16'h000a);
        global_shutter_i = 0;
        repeat (6) begin
            line_tick_i = ~line_tick_i;
            step(1);
            chk({15'h0000, exposure_tick_o}, {15'h0000, line_tick_i});
        end
        $display("test time base done");
        stop_test;
    end
endmodule // exposure_gain_sync_regs_tb
